//--- bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation signals.
  // ----------------------------------------------------------------
  logic clk_i = 1'b0; // Bench clock, 25 MHz.
  logic reset_n_i = 1'b0; // Reset, held low at start.
  logic [31:0] adr = 32'h0000_0000; // Bus address.
  logic rd = 1'b0; // Read request.
  logic wr = 1'b0; // Write request.
  logic [31:0] wdat = 32'h0000_0000; // Write data.
  logic [3:0] be = 4'h0; // Byte enables.
  logic [31:0] rdat; // Read data from the slave.
  logic wreq; // Waitrequest from the slave.
  logic match_irq; // Match pulse.
  logic irq; // Level interrupt.
  logic [31:0] got; // Last read value.
  int mismatches = 0; // Failed comparisons.
  int comparisons = 0; // All comparisons.
  int cycles = 0; // Timeout counter.
  int gap; // Measured match period.
  int n; // Scratch count.

  // The clock toggles every half period.
  always #20 clk_i = ~clk_i;

  itm_top u_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq),
    .match_irq_o(match_irq),
    .irq_o(irq)
  );

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("Comparisons %0d mismatches %0d.", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Compares one value and reports a difference at once.
  task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One Avalon cycle, held until waitrequest is sampled low.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // Counts the cycles between the next two match pulses.
  task measure(output int g);
    g = 0;
    do @(posedge clk_i); while (match_irq !== 1'b1);
    do begin
      @(posedge clk_i);
      g++;
    end while (match_irq !== 1'b1);
  endtask : measure

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Reset values and an unmapped address.
    bus(1'b0, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0000, 4'hF);
    chk("control reset", 32'h0000_0000, got);
    bus(1'b0, itm_pkg::ITM_CMP_ADDR, 32'h0000_0000, 4'hF);
    chk("compare reset", 32'h0000_0000, got);
    bus(1'b0, 32'hFFFF_F550, 32'h0000_0000, 4'hF);
    chk("unmapped read", 32'h0000_0000, got);
    // A compare write on one lane only is refused.
    bus(1'b1, itm_pkg::ITM_CMP_ADDR, 32'h0000_1234, 4'h1);
    bus(1'b0, itm_pkg::ITM_CMP_ADDR, 32'h0000_0000, 4'hF);
    chk("compare half write", 32'h0000_0000, got);
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0005, 4'h1);
    bus(1'b0, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0000, 4'hF);
    chk("control readback", 32'h0000_0005, got);
    // Every clock select with compare values zero and one.
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 2; c++) begin
        bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'(s), 4'h1);
        bus(1'b1, itm_pkg::ITM_CMP_ADDR, 32'(c), 4'h3);
        bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0080 | 32'(s), 4'h1);
        measure(gap);
        chk("match period", 32'((c + 1) << s), 32'(gap));
        bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'(s), 4'h1);
      end
    end
    // A stopped timer raises no match.
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (match_irq !== 1'b0) n++;
    end
    chk("pulses while stopped", 32'h0000_0000, 32'(n));
    // Sticky status, mask and write-one clear.
    bus(1'b0, itm_pkg::ITM_STAT_ADDR, 32'h0000_0000, 4'hF);
    chk("status set", 32'h0000_0001, got);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    bus(1'b1, itm_pkg::ITM_MASK_ADDR, 32'h0000_0001, 4'h1);
    bus(1'b0, itm_pkg::ITM_MASK_ADDR, 32'h0000_0000, 4'hF);
    chk("irq unmasked", 32'h0000_0001, 32'(irq));
    bus(1'b1, itm_pkg::ITM_STAT_ADDR, 32'h0000_0001, 4'h1);
    bus(1'b0, itm_pkg::ITM_STAT_ADDR, 32'h0000_0000, 4'hF);
    chk("status cleared", 32'h0000_0000, got);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    // Rewriting the same values while running keeps the period.
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0000, 4'h1);
    bus(1'b1, itm_pkg::ITM_CMP_ADDR, 32'h0000_0002, 4'h3);
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0080, 4'h1);
    bus(1'b1, itm_pkg::ITM_CMP_ADDR, 32'h0000_0002, 4'h3);
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0080, 4'h1);
    measure(gap);
    chk("period after same write", 32'h0000_0003, 32'(gap));
    // Full-range compare: first match one count late.
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0000, 4'h1);
    bus(1'b1, itm_pkg::ITM_CMP_ADDR, 32'h0000_FFFF, 4'h3);
    bus(1'b1, itm_pkg::ITM_CTRL_ADDR, 32'h0000_0080, 4'h1);
    n = 0;
    while (match_irq !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk("first match window", 32'h0000_0001, 32'(n >= 65537 && n <= 65540));
    test_done();
  end
endmodule : tb_top
`default_nettype wire

//--- src/itm_pkg.sv
// Notes on behaviour
// - Hidden 16-bit up-counter on count clock.
// - Compare register, 16-bit transfers only, resets zero.
// - Control register, byte access, resets zero.
// - Run enable bit 7 stops and resets.
// - Bits 2..0 divide clock by two-power.
// - Stopped counter all ones, rolls to zero.
// - Match clears counter and raises interrupt.
// - Period is compare plus one counts.
// - Compare zero: match every count clock.
// - Compare all ones: full count, then match.
// - First match one count clock late.
// - Clear-and-restart only, no free running.
package itm_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the Avalon bus.
  // ----------------------------------------------------------------
  localparam logic [31:0] ITM_CTRL_ADDR = 32'hFFFF_F540; // Control register.
  localparam logic [31:0] ITM_CMP_ADDR = 32'hFFFF_F544; // Compare register.
  localparam logic [31:0] ITM_STAT_ADDR = 32'hFFFF_F548; // Sticky interrupt status.
  localparam logic [31:0] ITM_MASK_ADDR = 32'hFFFF_F54C; // Interrupt mask.

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int ITM_RUN_BIT = 7; // Run enable position in control.
  localparam int ITM_SEL_W = 3; // Width of the clock select field.
  localparam int ITM_CNT_W = 16; // Counter and compare width.
  localparam int ITM_PRE_W = 7; // Prescaler width, divide by up to 128.
  localparam logic [15:0] ITM_CNT_ALL = 16'hFFFF; // Counter value while stopped.
  localparam logic [15:0] ITM_CNT_ZERO = 16'h0000; // Counter value after a match.
  localparam logic [15:0] ITM_CMP_RST = 16'h0000; // Compare reset value.
  localparam logic [2:0] ITM_SEL_RST = 3'h0; // Clock select reset value.
  localparam logic [3:0] ITM_BE_CTRL = 4'h1; // Lane holding the control byte.
  localparam logic [3:0] ITM_BE_CMP = 4'h3; // Lanes a compare write must hold.
  localparam logic [31:0] ITM_RD_ZERO = 32'h0000_0000; // Answer for unmapped reads.

  // Control register as stored; bits 6..3 are not stored and read zero.
  typedef struct packed {
    logic run; // Run enable.
    logic [2:0] sel; // Count clock select.
  } itm_ctrl_s;

  // One Avalon request as seen by the slave.
  typedef struct packed {
    logic [31:0] addr; // Byte address.
    logic rd; // Read strobe.
    logic wr; // Write strobe.
    logic [31:0] wdata; // Write data.
    logic [3:0] be; // Byte enables.
  } itm_req_s;

endpackage : itm_pkg

//--- src/itm_top.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module itm_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic match_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  itm_pkg::itm_req_s req; // Bundled bus request.
  itm_pkg::itm_ctrl_s ctrl_q; // Run enable and clock select.
  logic [itm_pkg::ITM_CNT_W-1:0] cmp_q; // Compare register.
  logic [itm_pkg::ITM_CNT_W-1:0] cnt_q; // Hidden counter.
  logic [itm_pkg::ITM_PRE_W-1:0] pre_q; // Prescaler of the peripheral clock.
  logic started_q; // High once the first count clock after start has passed.
  logic tick; // One-cycle count clock enable.
  logic match_q; // Match pulse register.
  logic stat_q; // Sticky match status.
  logic mask_q; // Match interrupt mask.
  logic irq_q; // Level interrupt register.
  logic wait_q; // Waitrequest register.
  logic [31:0] rdata_q; // Read data register.
  logic wr_go; // Write takes effect this edge.
  logic [itm_pkg::ITM_PRE_W-1:0] pre_mask; // Low prescaler bits that must be ones.

  assign req = '{addr: avs_address_i, rd: avs_read_i, wr: avs_write_i,
                 wdata: avs_writedata_i, be: avs_byteenable_i};

  // Decodes an address against one register address.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // ----------------------------------------------------------------
  // Avalon slave handshake.
  // ----------------------------------------------------------------

  // Waitrequest drops for one cycle per request, then rises again.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
    end else if ((req.rd || req.wr) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // A write lands at the edge where the master sees waitrequest low.
  assign wr_go = req.wr && !wait_q;

  // Read data is loaded one edge before the master takes it.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= itm_pkg::ITM_RD_ZERO;
    end else if (req.rd && wait_q) begin
      if (hit(req.addr, itm_pkg::ITM_CTRL_ADDR)) begin
        rdata_q <= {24'h00_0000, ctrl_q.run, 4'h0, ctrl_q.sel};
      end else if (hit(req.addr, itm_pkg::ITM_CMP_ADDR)) begin
        rdata_q <= {16'h0000, cmp_q};
      end else if (hit(req.addr, itm_pkg::ITM_STAT_ADDR)) begin
        rdata_q <= {31'h0000_0000, stat_q};
      end else if (hit(req.addr, itm_pkg::ITM_MASK_ADDR)) begin
        rdata_q <= {31'h0000_0000, mask_q};
      end else begin
        rdata_q <= itm_pkg::ITM_RD_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers.
  // ----------------------------------------------------------------

  // Control register; only the low byte lane carries it.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= '{run: 1'b0, sel: itm_pkg::ITM_SEL_RST};
    end else if (wr_go && hit(req.addr, itm_pkg::ITM_CTRL_ADDR) && req.be[0]) begin
      ctrl_q.run <= req.wdata[itm_pkg::ITM_RUN_BIT];
      ctrl_q.sel <= req.wdata[itm_pkg::ITM_SEL_W-1:0];
    end
  end

  // Compare register; partial-width writes are dropped.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_q <= itm_pkg::ITM_CMP_RST;
    end else if (wr_go && hit(req.addr, itm_pkg::ITM_CMP_ADDR)
                 && ((req.be & itm_pkg::ITM_BE_CMP) == itm_pkg::ITM_BE_CMP)) begin
      cmp_q <= req.wdata[itm_pkg::ITM_CNT_W-1:0];
    end
  end

  // Mask register.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q <= 1'b0;
    end else if (wr_go && hit(req.addr, itm_pkg::ITM_MASK_ADDR) && req.be[0]) begin
      mask_q <= req.wdata[0];
    end
  end

  // Sticky status; a match in the clearing cycle wins over the clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_q <= 1'b0;
    end else if (match_q) begin
      stat_q <= 1'b1;
    end else if (wr_go && hit(req.addr, itm_pkg::ITM_STAT_ADDR) && req.be[0] && req.wdata[0]) begin
      stat_q <= 1'b0;
    end
  end

  // Level interrupt, high while the unmasked status bit is set.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= stat_q && mask_q;
    end
  end

  // ----------------------------------------------------------------
  // Count clock generation.
  // ----------------------------------------------------------------

  // Prescaler runs only while enabled; stopping holds the count clock low.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= '0;
    end else if (!ctrl_q.run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Select 0 ticks every cycle; select k ticks when k low bits are ones.
  assign pre_mask = itm_pkg::ITM_PRE_W'((1 << ctrl_q.sel) - 1);
  assign tick = ctrl_q.run && ((pre_q & pre_mask) == pre_mask);

  // ----------------------------------------------------------------
  // Counter and match.
  // ----------------------------------------------------------------

  // First tick after start rolls all ones to zero without matching.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      started_q <= 1'b0;
    end else if (!ctrl_q.run) begin
      started_q <= 1'b0;
    end else if (tick) begin
      started_q <= 1'b1;
    end
  end

  // Counter clears on a match and on the first tick after start; on other ticks it steps up by one.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= itm_pkg::ITM_CNT_ALL;
    end else if (!ctrl_q.run) begin
      cnt_q <= itm_pkg::ITM_CNT_ALL;
    end else if (tick) begin
      if (!started_q) begin
        cnt_q <= itm_pkg::ITM_CNT_ZERO;
      end else if (cnt_q == cmp_q) begin
        cnt_q <= itm_pkg::ITM_CNT_ZERO;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Match request pulses for one cycle per match.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      match_q <= 1'b0;
    end else begin
      match_q <= tick && started_q && (cnt_q == cmp_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign match_irq_o = match_q;
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Start of a run and its first count clock.
  sequence run_start_s;
    !ctrl_q.run ##1 ctrl_q.run;
  endsequence
  sequence first_tick_s;
    tick && !started_q;
  endsequence

  stop_hold_a: assert property (!ctrl_q.run |=> cnt_q == itm_pkg::ITM_CNT_ALL)
    else $error("Counter not held at all ones while stopped.");
  first_roll_a: assert property (first_tick_s |=> cnt_q == itm_pkg::ITM_CNT_ZERO && !match_q)
    else $error("First count clock did not roll to zero quietly.");
  start_fast_a: assert property (run_start_s ##0 (ctrl_q.sel == 3'h0) |-> first_tick_s)
    else $error("Undivided clock did not tick at once after start.");
  match_clear_a: assert property (tick && started_q && cnt_q == cmp_q
                                  |=> cnt_q == itm_pkg::ITM_CNT_ZERO && match_q)
    else $error("Match did not clear counter and raise request.");
  count_up_a: assert property (tick && started_q && cnt_q != cmp_q
                               |=> cnt_q == $past(cnt_q) + 16'h0001 && !match_q)
    else $error("Counter did not step by one without match.");
  zero_cmp_a: assert property (started_q && cmp_q == 16'h0000 && ctrl_q.run |-> cnt_q == 16'h0000)
    else $error("Counter left zero with zero compare.");
  full_cmp_a: assert property (tick && started_q && cnt_q == 16'hFFFF && cmp_q == 16'hFFFF
                               |=> match_q && cnt_q == 16'h0000)
    else $error("All-ones compare did not match at all ones.");
  match_src_a: assert property (match_q |-> $past(tick) && $past(started_q))
    else $error("Match pulse without a count clock.");
  div_two_a: assert property (ctrl_q.run && ctrl_q.sel == 3'h1 && tick |=> !tick)
    else $error("Divide by two ticked on consecutive cycles.");
  cmp_part_a: assert property (wr_go && hit(req.addr, itm_pkg::ITM_CMP_ADDR) && req.be[1:0] != 2'b11
                               |=> $stable(cmp_q))
    else $error("Partial compare write changed the register.");
  ctrl_rsvd_a: assert property (!wait_q && req.rd && hit(req.addr, itm_pkg::ITM_CTRL_ADDR)
                                |-> rdata_q[6:3] == 4'h0)
    else $error("Control bits 6 to 3 did not read zero.");

  // ----------------------------------------------------------------
  // Assertions on the bus handshake and the registers.
  // ----------------------------------------------------------------
  // A request is taken with one wait cycle, then waitrequest rises again.
  wait_drop_a: assert property ((req.rd || req.wr) && wait_q |=> !wait_q)
    else $error("Waitrequest did not drop after a request.");
  wait_rise_a: assert property (!wait_q |=> wait_q)
    else $error("Waitrequest stayed low for a second cycle.");
  // Read data taken by the master stays put until the next read.
  read_hold_a: assert property (!wait_q |=> $stable(rdata_q))
    else $error("Read data changed after the master took it.");
  // Unmapped addresses read as zero.
  read_zero_a: assert property (!wait_q && req.rd && !hit(req.addr, itm_pkg::ITM_CTRL_ADDR)
                                && !hit(req.addr, itm_pkg::ITM_CMP_ADDR) && !hit(req.addr, itm_pkg::ITM_STAT_ADDR)
                                && !hit(req.addr, itm_pkg::ITM_MASK_ADDR) |-> rdata_q == itm_pkg::ITM_RD_ZERO)
    else $error("Unmapped read did not return zero.");

  // A full compare write stores the low half of the write data.
  cmp_write_a: assert property (wr_go && hit(req.addr, itm_pkg::ITM_CMP_ADDR) && req.be[1:0] == 2'b11
                                |=> cmp_q == 16'($past(req.wdata)))
    else $error("Full compare write did not store its data.");
  // A control write stores the clock select from the low bits.
  sel_write_a: assert property (wr_go && hit(req.addr, itm_pkg::ITM_CTRL_ADDR) && req.be[0]
                                |=> ctrl_q.sel == 3'($past(req.wdata)))
    else $error("Control write did not store the clock select.");

  // A match sets the sticky status and wins over a clear in the same cycle.
  stat_set_a: assert property (match_q |=> stat_q)
    else $error("Match did not set the status bit.");
  // A clear with no match in the same cycle empties the status.
  stat_clear_a: assert property (wr_go && hit(req.addr, itm_pkg::ITM_STAT_ADDR) && req.be[0] && req.wdata[0]
                                 && !match_q |=> !stat_q)
    else $error("Status write of one did not clear the bit.");
  // The level interrupt follows the unmasked status one cycle later.
  irq_level_a: assert property (stat_q && mask_q |=> irq_q)
    else $error("Interrupt not raised for an unmasked status.");
  irq_quiet_a: assert property (!(stat_q && mask_q) |=> !irq_q)
    else $error("Interrupt raised without an unmasked status.");

  // ----------------------------------------------------------------
  // Assertions on the stopped clock and the match period.
  // ----------------------------------------------------------------
  // While stopped the prescaler is cleared and nothing matches.
  pre_stop_a: assert property (!ctrl_q.run |=> pre_q == '0)
    else $error("Prescaler not cleared while stopped.");
  match_stop_a: assert property (!ctrl_q.run |=> !match_q)
    else $error("Match request raised while stopped.");
  // A fresh start finds the counter still at all ones.
  start_full_a: assert property (run_start_s |-> cnt_q == itm_pkg::ITM_CNT_ALL)
    else $error("Counter not at all ones when the run started.");
  // With compare zero every count clock after the first is a match.
  zero_match_a: assert property (tick && started_q && cmp_q == 16'h0000 |=> match_q)
    else $error("Zero compare missed a match.");

  // Steady undivided run with a compare value of one.
  sequence fast_one_s;
    ctrl_q.run && ctrl_q.sel == 3'h0 && cmp_q == 16'h0001;
  endsequence
  // An undivided run with compare one matches every second cycle.
  period_two_a: assert property (match_q ##0 fast_one_s ##1 fast_one_s |=> match_q)
    else $error("Compare one did not give a period of two.");

endmodule : itm_top
`default_nettype wire
